// ===== logic/exec_unit_pkg.sv
// Purpose: Shared constants and types for the subtract/xor/swap execution unit
// Assumes: APB with 32-bit data, 12-bit byte address
// Notes: Register file window holds 128 bytes, one per aligned word
package exec_unit_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_AW = 7;
  // Register byte offsets
  localparam logic [11:0] OFS_INSTR = 12'h000;
  localparam logic [11:0] OFS_ACC = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_CTRL = 12'h00C;
  localparam logic [11:0] OFS_WDT = 12'h010;
  localparam logic [11:0] OFS_DIR_A = 12'h014;
  localparam logic [11:0] OFS_DIR_B = 12'h018;
  localparam logic [11:0] OFS_DIR_C = 12'h01C;
  localparam logic [2:0] REGFILE_SEL = 3'h1;
  // Status bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;
  // Control bit positions
  localparam int CTRL_WAKE = 0;
  // Reset values, and the watchdog count loaded on sleep
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] WDT_CLEARED = 8'h00;
  // Direction operand codes
  localparam logic [7:0] DIR_OPND_A = 8'h05;
  localparam logic [7:0] DIR_OPND_B = 8'h06;
  localparam logic [7:0] DIR_OPND_C = 8'h07;
  typedef enum logic [3:0] {
    OP_SUB_FROM_LITERAL = 4'h1,
    OP_SUB_ACC_FROM_REG = 4'h2,
    OP_SUB_ACC_FROM_REG_BORROW = 4'h3,
    OP_NIBBLE_SWAP = 4'h4,
    OP_XOR_WITH_LITERAL = 4'h5,
    OP_XOR_WITH_REG = 4'h6,
    OP_LOAD_DIRECTION = 4'h7,
    OP_SLEEP = 4'h8
  } opcode_type;
  typedef struct packed {
    logic [3:0] opcode;
    logic dest;
    logic [7:0] operand;
  } instr_type;
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_ASLEEP = 2'b10
  } power_state_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;
endpackage : exec_unit_pkg

// ===== logic/subtract_xor_swap_exec_unit.sv
// Purpose: Executes subtract, xor, nibble swap, direction load and sleep
// Assumes: APB master, instructions issued by writing the instruction register
// Notes: One wait state on every APB access
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
module subtract_xor_swap_exec_unit #(
  parameter int WDT_PRE_W = 8,
  parameter int WDT_CNT_W = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire exec_unit_pkg::apb_req_type apbReq,
  output exec_unit_pkg::apb_rsp_type apbRsp,
  output logic [7:0] portADir,
  output logic [7:0] portBDir,
  output logic [7:0] portCDir,
  output logic sleepMode,
  output logic oscEnable
);

  generate
    if (WDT_PRE_W < 1 || WDT_PRE_W > 16 || WDT_CNT_W < 1 || WDT_CNT_W > 16) begin : g_chk
      $error("Watchdog widths must lie between 1 and 16");
    end
  endgenerate

  exec_unit_pkg::apb_rsp_type rsp_r;
  exec_unit_pkg::apb_rsp_type rsp_nxt;
  exec_unit_pkg::power_state_type state_r;
  exec_unit_pkg::power_state_type state_nxt;
  exec_unit_pkg::instr_type instr;
  exec_unit_pkg::instr_type lastInstr_r;
  exec_unit_pkg::instr_type lastInstr_nxt;
  logic [7:0] regFile [0:127];
  logic [7:0] acc_r;
  logic [7:0] acc_nxt;
  logic carry_r;
  logic carry_nxt;
  logic digit_r;
  logic digit_nxt;
  logic zero_r;
  logic zero_nxt;
  logic pdN_r;
  logic pdN_nxt;
  logic toN_r;
  logic toN_nxt;
  logic [7:0] dirA_r;
  logic [7:0] dirA_nxt;
  logic [7:0] dirB_r;
  logic [7:0] dirB_nxt;
  logic [7:0] dirC_r;
  logic [7:0] dirC_nxt;
  logic osc_r;
  logic osc_nxt;
  logic [WDT_PRE_W-1:0] wdtPre_r;
  logic [WDT_PRE_W-1:0] wdtPre_nxt;
  logic [WDT_CNT_W-1:0] wdtCnt_r;
  logic [WDT_CNT_W-1:0] wdtCnt_nxt;
  logic access;
  logic done;
  logic isRegWin;
  logic [6:0] winIdx;
  logic [7:0] opReg;
  logic badInstr;
  logic errNow;
  logic [31:0] rdNow;
  logic doInstr;
  logic regWe;
  logic [6:0] regWa;
  logic [7:0] regWd;
  logic [7:0] subA;
  logic [7:0] subB;
  logic subCin;
  logic [8:0] subSum;
  logic [4:0] subLow;
  logic [7:0] result;
  logic wdtClear;

  assign access = apbReq.psel & apbReq.penable;
  assign done = access & rsp_r.pready;
  assign isRegWin = apbReq.paddr[11:9] == exec_unit_pkg::REGFILE_SEL;
  assign winIdx = apbReq.paddr[8:2];
  assign instr = exec_unit_pkg::instr_type'(apbReq.pwdata[12:0]);
  assign opReg = regFile[instr.operand[6:0]];
  assign doInstr = done & apbReq.pwrite & ~errNow
      & (apbReq.paddr == exec_unit_pkg::OFS_INSTR);

  // Instruction legality; refused while asleep
  always_comb begin
    badInstr = 1'b0;
    unique case (instr.opcode)
      exec_unit_pkg::OP_SUB_FROM_LITERAL,
      exec_unit_pkg::OP_SUB_ACC_FROM_REG,
      exec_unit_pkg::OP_SUB_ACC_FROM_REG_BORROW,
      exec_unit_pkg::OP_NIBBLE_SWAP,
      exec_unit_pkg::OP_XOR_WITH_LITERAL,
      exec_unit_pkg::OP_XOR_WITH_REG,
      exec_unit_pkg::OP_SLEEP: badInstr = 1'b0;
      exec_unit_pkg::OP_LOAD_DIRECTION: begin
        badInstr = instr.operand != exec_unit_pkg::DIR_OPND_A
            && instr.operand != exec_unit_pkg::DIR_OPND_B
            && instr.operand != exec_unit_pkg::DIR_OPND_C;
      end
      default: badInstr = 1'b1;
    endcase
    if (state_r == exec_unit_pkg::ST_ASLEEP) begin
      badInstr = 1'b1;
    end
  end

  // Read mux and address decode
  always_comb begin
    rdNow = 32'h0000_0000;
    errNow = 1'b0;
    if (isRegWin) begin
      rdNow[7:0] = regFile[winIdx];
    end else begin
      unique case (apbReq.paddr)
        exec_unit_pkg::OFS_INSTR: begin
          rdNow[12:0] = lastInstr_r;
          errNow = apbReq.pwrite & badInstr;
        end
        exec_unit_pkg::OFS_ACC: rdNow[7:0] = acc_r;
        exec_unit_pkg::OFS_STATUS: begin
          rdNow[exec_unit_pkg::ST_CARRY] = carry_r;
          rdNow[exec_unit_pkg::ST_DIGIT] = digit_r;
          rdNow[exec_unit_pkg::ST_ZERO] = zero_r;
          rdNow[exec_unit_pkg::ST_PD_N] = pdN_r;
          rdNow[exec_unit_pkg::ST_TO_N] = toN_r;
        end
        exec_unit_pkg::OFS_CTRL: begin
          rdNow[exec_unit_pkg::CTRL_WAKE] = state_r == exec_unit_pkg::ST_ASLEEP;
        end
        exec_unit_pkg::OFS_WDT: begin
          rdNow[WDT_CNT_W-1:0] = wdtCnt_r;
          rdNow[16+WDT_PRE_W-1:16] = wdtPre_r;
        end
        exec_unit_pkg::OFS_DIR_A: rdNow[7:0] = dirA_r;
        exec_unit_pkg::OFS_DIR_B: rdNow[7:0] = dirB_r;
        exec_unit_pkg::OFS_DIR_C: rdNow[7:0] = dirC_r;
        default: errNow = 1'b1;
      endcase
    end
  end

  // APB answer: one wait state, data and error registered
  always_comb begin
    rsp_nxt.prdata = 32'h0000_0000;
    rsp_nxt.pready = 1'b0;
    rsp_nxt.pslverr = 1'b0;
    if (access && !rsp_r.pready) begin
      rsp_nxt.pready = 1'b1;
      rsp_nxt.pslverr = errNow;
      rsp_nxt.prdata = apbReq.pwrite ? 32'h0000_0000 : rdNow;
    end
  end

  // Shared subtractor: a + ~b + cin
  always_comb begin
    subA = opReg;
    subB = acc_r;
    subCin = 1'b1;
    if (instr.opcode == exec_unit_pkg::OP_SUB_FROM_LITERAL) begin
      subA = instr.operand;
    end
    if (instr.opcode == exec_unit_pkg::OP_SUB_ACC_FROM_REG_BORROW) begin
      subCin = carry_r;
    end
    subSum = {1'b0, subA} + {1'b0, ~subB} + {8'h00, subCin};
    subLow = {1'b0, subA[3:0]} + {1'b0, ~subB[3:0]} + {4'h0, subCin};
  end

  // Execution and software writes
  always_comb begin
    acc_nxt = acc_r;
    carry_nxt = carry_r;
    digit_nxt = digit_r;
    zero_nxt = zero_r;
    pdN_nxt = pdN_r;
    toN_nxt = toN_r;
    dirA_nxt = dirA_r;
    dirB_nxt = dirB_r;
    dirC_nxt = dirC_r;
    state_nxt = state_r;
    osc_nxt = osc_r;
    lastInstr_nxt = lastInstr_r;
    regWe = 1'b0;
    regWa = instr.operand[6:0];
    regWd = 8'h00;
    result = 8'h00;
    wdtClear = 1'b0;
    if (doInstr) begin
      lastInstr_nxt = instr;
      unique case (instr.opcode)
        exec_unit_pkg::OP_SUB_FROM_LITERAL,
        exec_unit_pkg::OP_SUB_ACC_FROM_REG,
        exec_unit_pkg::OP_SUB_ACC_FROM_REG_BORROW: begin
          result = subSum[7:0];
          carry_nxt = subSum[8];
          digit_nxt = subLow[4];
          zero_nxt = result == 8'h00;
        end
        exec_unit_pkg::OP_NIBBLE_SWAP: begin
          result = {opReg[3:0], opReg[7:4]};
        end
        exec_unit_pkg::OP_XOR_WITH_LITERAL: begin
          result = acc_r ^ instr.operand;
          zero_nxt = result == 8'h00;
        end
        exec_unit_pkg::OP_XOR_WITH_REG: begin
          result = acc_r ^ opReg;
          zero_nxt = result == 8'h00;
        end
        exec_unit_pkg::OP_LOAD_DIRECTION: begin
          if (instr.operand == exec_unit_pkg::DIR_OPND_A) begin
            dirA_nxt = acc_r;
          end
          if (instr.operand == exec_unit_pkg::DIR_OPND_B) begin
            dirB_nxt = acc_r;
          end
          if (instr.operand == exec_unit_pkg::DIR_OPND_C) begin
            dirC_nxt = acc_r;
          end
        end
        exec_unit_pkg::OP_SLEEP: begin
          pdN_nxt = 1'b0;
          toN_nxt = 1'b1;
          wdtClear = 1'b1;
          state_nxt = exec_unit_pkg::ST_ASLEEP;
          osc_nxt = 1'b0;
        end
        default: result = 8'h00;
      endcase
      // Literal forms and direction load have no destination choice
      if (instr.opcode == exec_unit_pkg::OP_SUB_FROM_LITERAL
          || instr.opcode == exec_unit_pkg::OP_XOR_WITH_LITERAL) begin
        acc_nxt = result;
      end
      if (instr.opcode == exec_unit_pkg::OP_SUB_ACC_FROM_REG
          || instr.opcode == exec_unit_pkg::OP_SUB_ACC_FROM_REG_BORROW
          || instr.opcode == exec_unit_pkg::OP_NIBBLE_SWAP
          || instr.opcode == exec_unit_pkg::OP_XOR_WITH_REG) begin
        if (instr.dest) begin
          regWe = 1'b1;
          regWd = result;
        end else begin
          acc_nxt = result;
        end
      end
    end else if (done && apbReq.pwrite && !errNow) begin
      if (isRegWin) begin
        regWe = 1'b1;
        regWa = winIdx;
        regWd = apbReq.pwdata[7:0];
      end else if (apbReq.paddr == exec_unit_pkg::OFS_ACC) begin
        acc_nxt = apbReq.pwdata[7:0];
      end else if (apbReq.paddr == exec_unit_pkg::OFS_STATUS) begin
        carry_nxt = apbReq.pwdata[exec_unit_pkg::ST_CARRY];
        digit_nxt = apbReq.pwdata[exec_unit_pkg::ST_DIGIT];
        zero_nxt = apbReq.pwdata[exec_unit_pkg::ST_ZERO];
      end else if (apbReq.paddr == exec_unit_pkg::OFS_CTRL
          && apbReq.pwdata[exec_unit_pkg::CTRL_WAKE]) begin
        state_nxt = exec_unit_pkg::ST_RUN;
        osc_nxt = 1'b1;
      end
    end
  end

  // Watchdog runs only while the oscillator runs
  always_comb begin
    wdtPre_nxt = wdtPre_r;
    wdtCnt_nxt = wdtCnt_r;
    if (wdtClear) begin
      wdtPre_nxt = '0;
      wdtCnt_nxt = WDT_CNT_W'(exec_unit_pkg::WDT_CLEARED);
    end else if (osc_r) begin
      wdtPre_nxt = wdtPre_r + 1'b1;
      if (&wdtPre_r) begin
        wdtCnt_nxt = wdtCnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (regWe) begin
      regFile[regWa] <= regWd;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rsp_r <= '0;
      state_r <= exec_unit_pkg::ST_RUN;
      lastInstr_r <= '0;
      acc_r <= exec_unit_pkg::ACC_RST;
      carry_r <= 1'b0;
      digit_r <= 1'b0;
      zero_r <= 1'b0;
      pdN_r <= 1'b1;
      toN_r <= 1'b1;
      dirA_r <= exec_unit_pkg::DIR_RST;
      dirB_r <= exec_unit_pkg::DIR_RST;
      dirC_r <= exec_unit_pkg::DIR_RST;
      osc_r <= 1'b1;
      wdtPre_r <= '0;
      wdtCnt_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
      state_r <= state_nxt;
      lastInstr_r <= lastInstr_nxt;
      acc_r <= acc_nxt;
      carry_r <= carry_nxt;
      digit_r <= digit_nxt;
      zero_r <= zero_nxt;
      pdN_r <= pdN_nxt;
      toN_r <= toN_nxt;
      dirA_r <= dirA_nxt;
      dirB_r <= dirB_nxt;
      dirC_r <= dirC_nxt;
      osc_r <= osc_nxt;
      wdtPre_r <= wdtPre_nxt;
      wdtCnt_r <= wdtCnt_nxt;
    end
  end

  assign apbRsp = rsp_r;
  assign portADir = dirA_r;
  assign portBDir = dirB_r;
  assign portCDir = dirC_r;
  // One-hot asleep bit, straight from its flop
  assign sleepMode = state_r[1];
  assign oscEnable = osc_r;

endmodule : subtract_xor_swap_exec_unit

// ===== testbench/subtract_xor_swap_exec_unit_asserts.sv
// Purpose: Port-level assertions for the execution unit
// Assumes: One wait state on every bus access
// Notes: Bound to every instance of the unit
`timescale 1ns/1ps
module subtract_xor_swap_exec_unit_asserts (
  input wire logic core_clk,
  input wire logic srst,
  input wire exec_unit_pkg::apb_req_type apbReq,
  input wire exec_unit_pkg::apb_rsp_type apbRsp,
  input wire logic [7:0] portADir,
  input wire logic [7:0] portBDir,
  input wire logic [7:0] portCDir,
  input wire logic sleepMode,
  input wire logic oscEnable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic commit;
  logic instr;
  assign commit = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
  assign instr = commit && apbReq.paddr == exec_unit_pkg::OFS_INSTR;
  a_one_wait: assert property (apbReq.psel && !apbReq.penable ##1 apbReq.psel
    && apbReq.penable |=> apbRsp.pready) else $error("ready not after one wait");
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held");
  a_err_with_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("error without ready");
  a_reg_range: assert property (
    apbRsp.pready && apbReq.paddr >= 12'h400 |-> apbRsp.pslverr)
    else $error("address beyond register file accepted");
  a_osc_stopped: assert property (sleepMode |-> !oscEnable)
    else $error("oscillator runs while asleep");
  a_sleep_entry: assert property (
    $rose(sleepMode) |-> $past(instr && apbReq.pwdata[12:9] == 4'h8))
    else $error("sleep without instruction");
  a_halted_dirs: assert property (
    sleepMode |=> $stable({portADir, portBDir, portCDir}))
    else $error("direction changed while asleep");
  a_dir_a_sel: assert property (
    !$past(srst) && $changed(portADir) |->
    $past(instr && apbReq.pwdata[12:9] == 4'h7 && apbReq.pwdata[7:0] == 8'h05))
    else $error("port A direction changed without load");
  a_dir_c_sel: assert property (
    !$past(srst) && $changed(portCDir) |->
    $past(instr && apbReq.pwdata[12:9] == 4'h7 && apbReq.pwdata[7:0] == 8'h07))
    else $error("port C direction changed without load");
  c_sleep: cover property ($rose(sleepMode));
  c_error: cover property (apbRsp.pslverr);
  c_dir: cover property ($changed(portBDir));
endmodule : subtract_xor_swap_exec_unit_asserts

bind subtract_xor_swap_exec_unit subtract_xor_swap_exec_unit_asserts chk_i (
  .core_clk(core_clk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
  .portADir(portADir), .portBDir(portBDir), .portCDir(portCDir),
  .sleepMode(sleepMode), .oscEnable(oscEnable));

// ===== testbench/subtract_xor_swap_exec_unit_tb.sv
// Purpose: Self-checking bench for the execution unit
// Assumes: Flags read back through the status word
// Notes: Register file written before use
`timescale 1ns/1ps
module subtract_xor_swap_exec_unit_tb;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  exec_unit_pkg::apb_req_type req = '0;
  exec_unit_pkg::apb_rsp_type rsp;
  logic [7:0] dirA, dirB, dirC;
  logic sleepMode, oscEnable;
  logic [31:0] rd;
  logic er;
  int errors = 0;
  int tests_run = 0;
  subtract_xor_swap_exec_unit dut (.core_clk(core_clk), .srst(srst), .apbReq(req),
    .apbRsp(rsp), .portADir(dirA), .portBDir(dirB), .portCDir(dirC),
    .sleepMode(sleepMode), .oscEnable(oscEnable));
  initial forever #10 core_clk = ~core_clk;
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do @(posedge core_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : xfer
  task automatic rdc(input string s, input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(s, x, rd);
  endtask : rdc
  task automatic ex(input logic [3:0] op, input logic d, input logic [7:0] k);
    xfer(1'b1, exec_unit_pkg::OFS_INSTR, {19'h0, op, d, k});
  endtask : ex
  function automatic logic [11:0] fa(input logic [6:0] n);
    return {exec_unit_pkg::REGFILE_SEL, n, 2'b00};
  endfunction : fa
  task automatic pre(input logic [7:0] a, input logic [7:0] st);
    xfer(1'b1, exec_unit_pkg::OFS_ACC, {24'h0, a});
    xfer(1'b1, exec_unit_pkg::OFS_STATUS, {24'h0, st});
  endtask : pre
  task automatic post(input logic [7:0] a, input logic [7:0] st);
    rdc("acc", exec_unit_pkg::OFS_ACC, {24'h0, a});
    rdc("status", exec_unit_pkg::OFS_STATUS, {24'h0, st});
  endtask : post
  task automatic t_reset();
    @(negedge core_clk);
    chk("dirs", 32'hFFFFFF, {8'h0, dirA, dirB, dirC});
    chk("run", 32'h1, {30'h0, sleepMode, oscEnable});
    post(8'h00, 8'h18);
  endtask : t_reset
  task automatic t_lit();
    pre(8'h05, 8'h00);
    ex(4'h1, 1'b0, 8'h05);
    post(8'h00, 8'h1F);
    pre(8'h10, 8'h04);
    ex(4'h1, 1'b0, 8'h0F);
    post(8'hFF, 8'h1A);
  endtask : t_lit
  task automatic t_reg();
    xfer(1'b1, fa(7'h7F), 32'h30);
    pre(8'h31, 8'h00);
    ex(4'h2, 1'b1, 8'h7F);
    post(8'h31, 8'h18);
    rdc("reg", fa(7'h7F), 32'hFF);
    ex(4'h2, 1'b0, 8'h7F);
    post(8'hCE, 8'h1B);
  endtask : t_reg
  task automatic t_borrow();
    xfer(1'b1, fa(7'h00), 32'h10);
    pre(8'h05, 8'h00);
    ex(4'h3, 1'b0, 8'h00);
    post(8'h0A, 8'h19);
    ex(4'h3, 1'b1, 8'h00);
    rdc("reg", fa(7'h00), 32'h06);
  endtask : t_borrow
  task automatic t_swap_xor();
    xfer(1'b1, fa(7'h01), 32'hA5);
    pre(8'h00, 8'h07);
    ex(4'h4, 1'b1, 8'h01);
    rdc("reg", fa(7'h01), 32'h5A);
    ex(4'h4, 1'b0, 8'h01);
    post(8'hA5, 8'h1F);
    pre(8'h3C, 8'h03);
    ex(4'h5, 1'b0, 8'h3C);
    post(8'h00, 8'h1F);
    pre(8'h0F, 8'h07);
    ex(4'h6, 1'b1, 8'h01);
    rdc("reg", fa(7'h01), 32'h55);
    post(8'h0F, 8'h1B);
  endtask : t_swap_xor
  task automatic t_dir();
    for (int i = 0; i < 3; i++) begin
      pre(8'h50 + 8'(i), 8'h07);
      ex(4'h7, 1'b0, 8'h05 + 8'(i));
      rdc("dir", exec_unit_pkg::OFS_DIR_A + 12'(4 * i), 32'h50 + i);
      post(8'h50 + 8'(i), 8'h1F);
    end
    chk("ports", 32'h505152, {8'h0, dirA, dirB, dirC});
    ex(4'h7, 1'b0, 8'h04);
    chk("bad dir", 32'h1, {31'h0, er});
    chk("ports kept", 32'h505152, {8'h0, dirA, dirB, dirC});
  endtask : t_dir
  task automatic t_sleep();
    pre(8'h00, 8'h07);
    repeat (600) @(posedge core_clk);
    ex(4'h8, 1'b0, 8'h00);
    @(negedge core_clk);
    chk("sleep", 32'h2, {30'h0, sleepMode, oscEnable});
    rdc("wdt", exec_unit_pkg::OFS_WDT, 32'h0);
    post(8'h00, 8'h17);
    rdc("asleep", exec_unit_pkg::OFS_CTRL, 32'h1);
    ex(4'h1, 1'b0, 8'h01);
    chk("halt", 32'h1, {31'h0, er});
    xfer(1'b1, exec_unit_pkg::OFS_CTRL, 32'h1);
    @(negedge core_clk);
    chk("wake", 32'h1, {30'h0, sleepMode, oscEnable});
    xfer(1'b0, 12'h400, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
  endtask : t_sleep
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_lit();
    t_reg();
    t_borrow();
    t_swap_xor();
    t_dir();
    t_sleep();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    conclude();
  end
endmodule : subtract_xor_swap_exec_unit_tb
